/* design/ufbec_ctrl.v */
// Flow characters, line errors, transmit break timing and turnaround delay
//
// Function
// RULE1: Resume character register, 5-8 bits used, resets to 0x11.
// RULE2: In software flow mode, receiving resume character restarts transmission.
// RULE3: In software flow mode, receiving pause character (reset 0x13) stops transmission.
// RULE4: For 9-bit characters only low eight bits used, ninth bit zero.
// RULE5: In multidrop mode resume register is the unicast address.
// RULE6: In multidrop mode pause register is the multicast address.
// RULE7: Error register accumulates events since last read; read clears them.
// RULE8: Bit 7 shows live break, not cleared by read.
// RULE9: Bit 6 sets on overrun, clears after read.
// RULE10: Bit 5 sets on parity error, clears after read.
// RULE11: Bit 4 sets on missing stop bit, clears after read.
// RULE12: Bit 3 latches a break occurrence, clears after read.
// RULE13: Break duration 0xffff drives break until rewritten.
// RULE14: Other nonzero values give that many ms, counting down each ms.
// RULE15: Writing zero ends any break in progress.
// RULE16: Every break write aborts the old operation and acts at once.
// RULE17: A character being shifted completes before break starts.
// RULE18: Break begins within 1 ms after nonzero write.
// RULE19: Break released within two character times after count reaches zero.
// RULE20: RS-485 direction returns to receive after 0-15 programmed bit times.
// RULE21: Software writes zeros to reserved upper bits.
// RULE22: Software disables UART before writing config registers.
// RULE23: Flow mode 010 enables software flow control.
// RULE24: Mode 011 gates receive by address match; 100 gates both.
// RULE25: While break asserted transmit output held low.
// RULE26: Break millisecond tick comes from a core clock prescaler.
`timescale 1ns/10ps
`include "ufbec_consts.vh"
module ufbec_ctrl #(
  parameter integer TICK_CYCLES = `UFBEC_TICK_CYCLES
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // Register port
  input  wire [11:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // Framing configuration
  input  wire        nine_bit_mode,
  // Receiver character and error events
  input  wire        rx_char_valid,
  input  wire [8:0]  rx_char,
  input  wire        rx_fifo_full,
  input  wire        rx_parity_err,
  input  wire        rx_framing_err,
  input  wire        rx_break_live,
  // Transmitter status
  input  wire        tx_shifting,
  input  wire        tx_serial_in,
  input  wire        tx_char_done,
  input  wire        tx_active,
  input  wire        bit_tick,
  // Control outputs
  output reg         tx_serial_out,
  output reg         tx_break_active,
  output reg         tx_flow_paused,
  output reg         addr_unicast_hit,
  output reg         addr_multicast_hit,
  output reg         rx_addr_gate,
  output reg         tx_addr_gate,
  output reg         rs485_drive
);

  localparam BRK_IDLE = 2'd0;
  localparam BRK_WAIT = 2'd1;
  localparam BRK_ON   = 2'd2;
  localparam BRK_TAIL = 2'd3;

  reg [2:0]  flow_mode_q;
  reg [7:0]  resume_char_q;
  reg [7:0]  pause_char_q;
  reg [3:0]  err_sticky_q;
  reg [15:0] break_duration_q;
  reg [3:0]  turn_delay_q;
  reg [1:0]  brk_state_q;
  reg [1:0]  tail_chars_q;
  reg [3:0]  turn_cnt_q;
  reg        turn_run_q;
  reg        tx_active_q;
  reg        break_live_q;
  reg [15:0] rdata_d;

  wire       wr_brk = reg_wr && (reg_addr == `UFBEC_OFS_BREAK_DUR);
  wire       rd_err = reg_rd && (reg_addr == `UFBEC_OFS_LINE_ERR);
  wire       ms_tick;
  wire       sw_flow = (flow_mode_q == `UFBEC_MODE_SW_FLOW);
  wire       mdrop = (flow_mode_q == `UFBEC_MODE_MDROP_RX) ||
                     (flow_mode_q == `UFBEC_MODE_MDROP_RXTX);
  wire [3:0] err_new;

  // ****************************************
  // Character compare with 9-bit handling
  // ****************************************
  function match_char;
    input [8:0] rx;
    input [7:0] ref_char;
    input       nine;
    begin
      if (nine)
        match_char = (rx == {1'b0, ref_char}); // [RULE4]
      else
        match_char = (rx[7:0] == ref_char);
    end
  endfunction

  // Restarted on a break write so the first millisecond is timed from the write
  ufbec_ms_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .restart (wr_brk),
    .tick    (ms_tick) // [RULE26]
  );

  // ****************************************
  // Configuration registers
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flow_mode_q   <= 3'h0;
      resume_char_q <= `UFBEC_RST_RESUME_CHAR; // [RULE1]
      pause_char_q  <= `UFBEC_RST_PAUSE_CHAR; // [RULE3]
      turn_delay_q  <= 4'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `UFBEC_OFS_FLOW_MODE:   flow_mode_q   <= reg_wdata[2:0]; // [RULE23]
        `UFBEC_OFS_RESUME_CHAR: resume_char_q <= reg_wdata[7:0]; // [RULE1]
        `UFBEC_OFS_PAUSE_CHAR:  pause_char_q  <= reg_wdata[7:0];
        `UFBEC_OFS_TURN_DELAY:  turn_delay_q  <= reg_wdata[3:0]; // [RULE20]
        default: ;
      endcase
    end
  end

  // ****************************************
  // Line error status
  // ****************************************
  // Order: overrun, parity, framing, break seen
  // Break seen on onset only, so a read clears it while the break lasts
  assign err_new = {rx_char_valid && rx_fifo_full, rx_char_valid && rx_parity_err,
                    rx_char_valid && rx_framing_err, rx_break_live && !break_live_q};

  // New event wins over the read clear in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_sticky_q <= 4'h0;
      break_live_q <= 1'b0;
    end else begin
      break_live_q <= rx_break_live;
      err_sticky_q <= (rd_err ? 4'h0 : err_sticky_q) | err_new; // [RULE7] [RULE9] [RULE10] [RULE11] [RULE12]
    end
  end

  // ****************************************
  // Flow control and address matching
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_flow_paused     <= 1'b0;
      addr_unicast_hit   <= 1'b0;
      addr_multicast_hit <= 1'b0;
      rx_addr_gate       <= 1'b0;
      tx_addr_gate       <= 1'b0;
    end else begin
      if (!sw_flow) begin
        tx_flow_paused <= 1'b0;
      end else if (rx_char_valid) begin
        if (match_char(rx_char, pause_char_q, nine_bit_mode))
          tx_flow_paused <= 1'b1; // [RULE3]
        else if (match_char(rx_char, resume_char_q, nine_bit_mode))
          tx_flow_paused <= 1'b0; // [RULE2]
      end
      // Address characters carry the ninth bit in multidrop
      addr_unicast_hit   <= mdrop && rx_char_valid && rx_char[8] &&
                            (rx_char[7:0] == resume_char_q); // [RULE5]
      addr_multicast_hit <= mdrop && rx_char_valid && rx_char[8] &&
                            (rx_char[7:0] == pause_char_q); // [RULE6]
      rx_addr_gate <= mdrop; // [RULE24]
      tx_addr_gate <= (flow_mode_q == `UFBEC_MODE_MDROP_RXTX); // [RULE24]
    end
  end

  // ****************************************
  // Transmit break sequencer
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      break_duration_q <= 16'h0;
      brk_state_q      <= BRK_IDLE;
      tail_chars_q     <= 2'd0;
    end else if (wr_brk) begin
      break_duration_q <= reg_wdata; // [RULE16]
      tail_chars_q     <= 2'd0;
      // A nonzero rewrite during a break keeps the line low with no one-cycle gap
      if (reg_wdata == `UFBEC_BREAK_NONE)
        brk_state_q <= BRK_IDLE; // [RULE15]
      else if (brk_state_q == BRK_ON)
        brk_state_q <= BRK_ON;
      else
        brk_state_q <= BRK_WAIT;
    end else begin
      case (brk_state_q)
        BRK_IDLE: brk_state_q <= BRK_IDLE;
        BRK_WAIT: begin
          if (!tx_shifting)
            brk_state_q <= BRK_ON; // [RULE17] [RULE18]
        end
        BRK_ON: begin
          if (break_duration_q == `UFBEC_BREAK_NONE) begin
            brk_state_q  <= BRK_TAIL;
            tail_chars_q <= 2'd0;
          end else if (ms_tick && break_duration_q != `UFBEC_BREAK_FOREVER) begin
            break_duration_q <= break_duration_q - 16'h1; // [RULE14] [RULE13]
          end
        end
        BRK_TAIL: begin
          // Break released on leaving BRK_ON; state waits here for the next character end before idle
          if (tx_char_done) begin
            if (tail_chars_q == 2'd0)
              brk_state_q <= BRK_IDLE; // [RULE19]
            else
              tail_chars_q <= tail_chars_q - 2'd1;
          end
        end
        default: brk_state_q <= BRK_IDLE;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_break_active <= 1'b0;
      tx_serial_out   <= 1'b1;
    end else begin
      tx_break_active <= (brk_state_q == BRK_ON);
      tx_serial_out   <= (brk_state_q == BRK_ON) ? 1'b0 : tx_serial_in; // [RULE25]
    end
  end

  // ****************************************
  // RS-485 turnaround delay
  // ****************************************
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_active_q <= 1'b0;
      turn_run_q  <= 1'b0;
      turn_cnt_q  <= 4'h0;
      rs485_drive <= 1'b0;
    end else begin
      tx_active_q <= tx_active;
      if (tx_active) begin
        turn_run_q  <= 1'b0;
        rs485_drive <= 1'b1;
      end else if (tx_active_q) begin
        turn_cnt_q <= turn_delay_q;
        if (turn_delay_q == 4'h0) begin
          rs485_drive <= 1'b0;
        end else begin
          turn_run_q <= 1'b1;
        end
      end else if (turn_run_q && bit_tick) begin
        if (turn_cnt_q == 4'h1) begin
          turn_run_q  <= 1'b0;
          rs485_drive <= 1'b0; // [RULE20]
        end
        turn_cnt_q <= turn_cnt_q - 4'h1;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  always @* begin
    rdata_d = 16'h0;
    case (reg_addr)
      `UFBEC_OFS_FLOW_MODE:   rdata_d = {13'h0, flow_mode_q};
      `UFBEC_OFS_RESUME_CHAR: rdata_d = {8'h0, resume_char_q};
      `UFBEC_OFS_PAUSE_CHAR:  rdata_d = {8'h0, pause_char_q};
      `UFBEC_OFS_LINE_ERR:    rdata_d = {8'h0, rx_break_live, err_sticky_q, 3'h0}; // [RULE8]
      `UFBEC_OFS_BREAK_DUR:   rdata_d = break_duration_q;
      `UFBEC_OFS_TURN_DELAY:  rdata_d = {12'h0, turn_delay_q};
      default:                rdata_d = 16'h0;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

/* design/ufbec_consts.vh */
// Register offsets, field positions, reset values and timing counts
`ifndef UFBEC_CONSTS_VH
`define UFBEC_CONSTS_VH

// ****************************************
// Register offsets (register port address)
// ****************************************
`define UFBEC_ADDR_W           12
`define UFBEC_OFS_FLOW_MODE    12'h006
`define UFBEC_OFS_RESUME_CHAR  12'h007
`define UFBEC_OFS_PAUSE_CHAR   12'h008
`define UFBEC_OFS_LINE_ERR     12'h009
`define UFBEC_OFS_BREAK_DUR    12'h00a
`define UFBEC_OFS_TURN_DELAY   12'h00b

// ****************************************
// Reset values
// ****************************************
`define UFBEC_RST_RESUME_CHAR  8'h11
`define UFBEC_RST_PAUSE_CHAR   8'h13

// ****************************************
// Field positions and encodings
// ****************************************
`define UFBEC_ERR_BREAK_LIVE   7
`define UFBEC_ERR_OVERRUN      6
`define UFBEC_ERR_PARITY       5
`define UFBEC_ERR_FRAMING      4
`define UFBEC_ERR_BREAK_SEEN   3
`define UFBEC_MODE_SW_FLOW     3'h2
`define UFBEC_MODE_MDROP_RX    3'h3
`define UFBEC_MODE_MDROP_RXTX  3'h4
`define UFBEC_BREAK_FOREVER    16'hffff
`define UFBEC_BREAK_NONE       16'h0000

// ****************************************
// Timing
// ****************************************
`define UFBEC_CLK_HZ           250000000
`define UFBEC_TICK_US          1000
`define UFBEC_TICK_CYCLES      ((`UFBEC_CLK_HZ / 1000000) * `UFBEC_TICK_US)

`endif

/* design/ufbec_ms_tick.v */
// Millisecond tick prescaler from the core clock
`timescale 1ns/10ps
`include "ufbec_consts.vh"
module ufbec_ms_tick #(
  parameter integer CYCLES = `UFBEC_TICK_CYCLES
) (
  // Clock and reset
  input  wire clk_sys,
  input  wire rst,
  // Restart the period
  input  wire restart,
  // One-cycle tick
  output reg  tick
);

  reg [31:0] cnt_q;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end else if (cnt_q == CYCLES - 1) begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end

endmodule

/* test/ufbec_ctrl_assertions.sv */
// Port-level checks of the flow, error and break control block
`timescale 1ns/10ps
module ufbec_ctrl_assertions (
  // Clock and reset
  input wire        clk_sys,
  input wire        rst,
  // Register port
  input wire [11:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // Receive events
  input wire        rx_char_valid,
  input wire [8:0]  rx_char,
  input wire        rx_fifo_full,
  input wire        rx_parity_err,
  input wire        rx_framing_err,
  // Transmit side and gates
  input wire        tx_shifting,
  input wire        tx_serial_in,
  input wire        tx_serial_out,
  input wire        tx_break_active,
  input wire        addr_unicast_hit,
  input wire        rx_addr_gate,
  input wire        tx_addr_gate
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire rd_err = reg_rd && (reg_addr == 12'h009);
  wire wr_brk = reg_wr && (reg_addr == 12'h00a);
  sequence s_ovr;
    rx_char_valid && rx_fifo_full ##2 rd_err;
  endsequence
  sequence s_par;
    rx_char_valid && rx_parity_err ##2 rd_err;
  endsequence
  sequence s_frm;
    rx_char_valid && rx_framing_err ##2 rd_err;
  endsequence
  property p_ovr;
    s_ovr |=> reg_rdata[6];
  endproperty
  property p_par;
    s_par |=> reg_rdata[5];
  endproperty
  property p_frm;
    s_frm |=> reg_rdata[4];
  endproperty
  property p_low;
    tx_break_active |-> !tx_serial_out;
  endproperty
  property p_pass;
    !tx_break_active && !$past(tx_break_active) && !$past(rst)
      |-> tx_serial_out == $past(tx_serial_in);
  endproperty
  property p_zero;
    wr_brk && reg_wdata == 16'h0000 |-> ##[1:2] !tx_break_active;
  endproperty
  property p_shift;
    $rose(tx_break_active) |-> !$past(tx_shifting);
  endproperty
  property p_gate;
    reg_wr && reg_addr == 12'h006 && reg_wdata[2:0] == 3'h4
      |-> ##[1:2] (rx_addr_gate && tx_addr_gate);
  endproperty
  property p_uni;
    addr_unicast_hit |-> $past(rx_char_valid) && $past(rx_char[8]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun flag missing");
  a_par: assert property (p_par) else $error("parity flag missing");
  a_frm: assert property (p_frm) else $error("framing flag missing");
  a_low: assert property (p_low) else $error("line not low in break");
  a_pass: assert property (p_pass) else $error("line not passed through");
  a_zero: assert property (p_zero) else $error("break kept after zero");
  a_shift: assert property (p_shift) else $error("break cut a character");
  a_gate: assert property (p_gate) else $error("address gates not set");
  a_uni: assert property (p_uni) else $error("hit without address");
endmodule
bind ufbec_ctrl ufbec_ctrl_assertions u_ufbec_ctrl_assertions (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rx_char_valid(rx_char_valid), .rx_char(rx_char), .rx_fifo_full(rx_fifo_full),
  .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
  .tx_shifting(tx_shifting), .tx_serial_in(tx_serial_in),
  .tx_serial_out(tx_serial_out), .tx_break_active(tx_break_active),
  .addr_unicast_hit(addr_unicast_hit), .rx_addr_gate(rx_addr_gate),
  .tx_addr_gate(tx_addr_gate));

/* test/ufbec_node.sv */
// Remote serial node: received characters, errors and line break
`timescale 1ns/10ps
module ufbec_node (
  // Clock
  input  wire       clk_sys,
  // Received character events
  output reg        rx_char_valid,
  output reg  [8:0] rx_char,
  output reg        rx_parity_err,
  output reg        rx_framing_err,
  output reg        rx_break_live
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 9'h000;
    rx_parity_err = 1'b0;
    rx_framing_err = 1'b0;
    rx_break_live = 1'b0;
  end
  // Outside the valid cycle the lines carry junk, never stale data
  task send(input [8:0] c, input p, input f);
    begin
      @(posedge clk_sys);
      rx_char_valid <= 1'b1;
      rx_char <= c;
      rx_parity_err <= p;
      rx_framing_err <= f;
      @(posedge clk_sys);
      rx_char_valid <= 1'b0;
      rx_char <= ~c;
      rx_parity_err <= ~p;
      rx_framing_err <= ~f;
    end
  endtask
  task brk(input b);
    begin
      @(posedge clk_sys);
      rx_break_live <= b;
    end
  endtask
endmodule

/* test/ufbec_ctrl_test.sv */
// Register-level bench of the flow, error and break control block
`timescale 1ns/10ps
module ufbec_ctrl_test;
  reg clk_sys, rst, reg_wr, reg_rd, nine_bit_mode, rx_fifo_full;
  reg tx_shifting, tx_serial_in, tx_char_done, tx_active, bit_tick;
  reg  [11:0] reg_addr;
  reg  [15:0] reg_wdata;
  reg  [5:0]  cyc;
  wire [15:0] reg_rdata;
  wire [8:0]  rx_char;
  wire rx_char_valid, rx_parity_err, rx_framing_err, rx_break_live;
  wire tx_serial_out, tx_break_active, tx_flow_paused, addr_unicast_hit;
  wire addr_multicast_hit, rx_addr_gate, tx_addr_gate, rs485_drive;
  integer n_errors, n_checks, n_cyc;
  ufbec_ctrl #(.TICK_CYCLES(20)) u_ufbec_ctrl (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .nine_bit_mode(nine_bit_mode), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .rx_fifo_full(rx_fifo_full), .rx_parity_err(rx_parity_err),
    .rx_framing_err(rx_framing_err), .rx_break_live(rx_break_live),
    .tx_shifting(tx_shifting), .tx_serial_in(tx_serial_in),
    .tx_char_done(tx_char_done), .tx_active(tx_active), .bit_tick(bit_tick),
    .tx_serial_out(tx_serial_out), .tx_break_active(tx_break_active),
    .tx_flow_paused(tx_flow_paused), .addr_unicast_hit(addr_unicast_hit),
    .addr_multicast_hit(addr_multicast_hit), .rx_addr_gate(rx_addr_gate),
    .tx_addr_gate(tx_addr_gate), .rs485_drive(rs485_drive));
  ufbec_node u_ufbec_node (
    .clk_sys(clk_sys), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err),
    .rx_break_live(rx_break_live));
  // ****************************************
  // Transmitter stand-in: bit every 4 cycles, character every 40
  // ****************************************
  always @(posedge clk_sys) begin
    cyc <= (cyc == 6'h27) ? 6'h00 : cyc + 6'h01;
    bit_tick <= (cyc[1:0] == 2'h3);
    tx_char_done <= (cyc == 6'h27);
    tx_serial_in <= ~tx_serial_in;
  end
  task conclude;
    begin
      if (n_errors == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] s, input [15:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [15:0] e);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
    end
  endtask
  // Bounded wait for the break output to reach a level
  task wb(input v, input integer lim);
    begin
      n_cyc = 0;
      while (tx_break_active !== v) begin
        @(posedge clk_sys);
        #1 n_cyc = n_cyc + 1;
        if (n_cyc > lim) begin
          n_errors = n_errors + 1;
          conclude;
        end
      end
    end
  endtask
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      #1;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, reg_wr, reg_rd, nine_bit_mode, rx_fifo_full, tx_active} = 6'h21;
    {tx_shifting, tx_serial_in, tx_char_done, bit_tick} = 4'h8;
    {reg_addr, reg_wdata, cyc, n_errors, n_checks} = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h007, 16'h0011);
    rd(12'h008, 16'h0013);
    rd(12'h009, 16'h0000);
    rd(12'h00a, 16'h0000);
    rd(12'h00b, 16'h0000);
    rd(12'h0ff, 16'h0000);
    // Error accumulation and read-clear
    @(posedge clk_sys) rx_fifo_full <= 1'b1;
    u_ufbec_node.send(9'h041, 1'b1, 1'b1);
    rd(12'h009, 16'h0070);
    rx_fifo_full <= 1'b0;
    rd(12'h009, 16'h0000);
    u_ufbec_node.brk(1'b1);
    step(3);
    rd(12'h009, 16'h0088);
    rd(12'h009, 16'h0080);
    u_ufbec_node.brk(1'b0);
    step(3);
    rd(12'h009, 16'h0000);
    // Software flow control; upper bits written as zero
    wr(12'h006, 16'h0002);
    u_ufbec_node.send(9'h013, 1'b0, 1'b0);
    step(1);
    chk({15'h0, tx_flow_paused}, 16'h0001);
    u_ufbec_node.send(9'h011, 1'b0, 1'b0);
    step(1);
    chk({15'h0, tx_flow_paused}, 16'h0000);
    nine_bit_mode <= 1'b1;
    u_ufbec_node.send(9'h113, 1'b0, 1'b0);
    step(1);
    chk({15'h0, tx_flow_paused}, 16'h0000);
    nine_bit_mode <= 1'b0;
    // Multidrop address matching
    wr(12'h006, 16'h0003);
    wr(12'h007, 16'h0025);
    rd(12'h007, 16'h0025);
    chk({14'h0, rx_addr_gate, tx_addr_gate}, 16'h0002);
    u_ufbec_node.send(9'h125, 1'b0, 1'b0);
    #1;
    chk({15'h0, addr_unicast_hit}, 16'h0001);
    u_ufbec_node.send(9'h113, 1'b0, 1'b0);
    #1;
    chk({15'h0, addr_multicast_hit}, 16'h0001);
    wr(12'h006, 16'h0004);
    step(2);
    chk({14'h0, rx_addr_gate, tx_addr_gate}, 16'h0003);
    wr(12'h006, 16'h0000);
    // Timed break behind a character still shifting
    wr(12'h00a, 16'h0003);
    step(10);
    chk({15'h0, tx_break_active}, 16'h0000);
    @(posedge clk_sys) tx_shifting <= 1'b0;
    wb(1'b1, 20);
    wb(1'b0, 160);
    chk({15'h0, n_cyc >= 40}, 16'h0001);
    wr(12'h00a, 16'hffff);
    wb(1'b1, 20);
    step(200);
    chk({15'h0, tx_break_active}, 16'h0001);
    wr(12'h00a, 16'h0002);
    wb(1'b0, 130);
    wr(12'h00a, 16'hffff);
    wb(1'b1, 20);
    wr(12'h00a, 16'h0000);
    wb(1'b0, 3);
    // Direction turnaround after three bit times
    wr(12'h00b, 16'h0003);
    @(posedge clk_sys) tx_active <= 1'b1;
    step(8);
    chk({15'h0, rs485_drive}, 16'h0001);
    @(posedge clk_sys) tx_active <= 1'b0;
    step(6);
    chk({15'h0, rs485_drive}, 16'h0001);
    step(12);
    chk({15'h0, rs485_drive}, 16'h0000);
    conclude;
  end
endmodule
